// ==== src/dpsc_pkg.sv ====
// shared constants and types of the drive power-state control block
package dpsc_pkg;

   localparam int CLK_NS = 10;
   // standby and power-management timers count in ticks of this length
   localparam int TICK_NS = 1_000_000;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   // longest wait for the host to answer a device-started low-power request
   localparam int REQ_TMO_NS = 10_000;
   localparam int REQ_TMO_CYC = REQ_TMO_NS / CLK_NS;

   // feature-setting subcommands
   localparam logic [7:0] SF_APM_ON = 8'h05;
   localparam logic [7:0] SF_APM_OFF = 8'h85;
   localparam logic [7:0] SF_PUIS_ON = 8'h0A;
   localparam logic [7:0] SF_PUIS_OFF = 8'h8A;
   localparam logic [7:0] SF_SPINUP = 8'h07;

   // power management level range, reset level and the band that allows standby
   localparam logic [7:0] APM_MIN = 8'h01;
   localparam logic [7:0] APM_MAX = 8'hFE;
   localparam logic [7:0] APM_RST_LVL = 8'h80;
   localparam logic [7:0] APM_STBY_BAND = 8'h80;

   // identify word bit positions
   localparam int ID_W0_INCOMPLETE_BIT = 2;
   localparam int ID_W83_APM_BIT = 3;
   localparam int ID_W86_APM_BIT = 3;

   typedef enum logic [1:0] {
      P_ACTIVE = 2'b00,
      P_STANDBY = 2'b01,
      P_PUIS = 2'b10
   } dpsc_pwr_t;

   typedef enum logic [2:0] {
      L_ACTIVE = 3'b000,
      L_REQ_P = 3'b001,
      L_PARTIAL = 3'b011,
      L_REQ_S = 3'b100,
      L_SLUMBER = 3'b101
   } dpsc_link_t;

   typedef struct packed {
      logic valid;
      logic [7:0] sub;
      logic [7:0] count;
   } dpsc_feat_t;

   typedef struct packed {
      logic pmreq_p;
      logic pmreq_s;
      logic pmack;
      logic pmnak;
   } dpsc_prim_t;

   typedef struct packed {
      logic comwake;
      logic comreset;
   } dpsc_oob_t;

   typedef struct packed {
      logic [15:0] w0;
      logic [15:0] w83;
      logic [15:0] w86;
      logic [15:0] w91;
   } dpsc_id_t;

endpackage : dpsc_pkg

// ==== src/dpsc_tick.sv ====
// divider that makes the timer tick enable
`timescale 1ns/1ps
`default_nettype none
module dpsc_tick #(
   parameter int CYC = dpsc_pkg::TICK_CYC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   output logic o_tick
);
   localparam int W = (CYC > 1) ? $clog2(CYC) : 1;

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic tick;
   logic next_tick;

   always_comb begin
      next_tick = (cnt == W'(CYC - 1));
      next_cnt = next_tick ? '0 : cnt + W'(1);
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt <= '0;
         tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         tick <= next_tick;
      end
   end

   assign o_tick = tick;
endmodule : dpsc_tick
`default_nettype wire

// ==== src/dpsc_timer.sv ====
// tick-counting timer that pulses once when its limit is reached
`timescale 1ns/1ps
`default_nettype none
module dpsc_timer #(
   parameter int W = 16
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_tick,
   input wire logic i_restart,
   input wire logic [W-1:0] i_limit,
   output logic o_expire
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic fired;
   logic next_fired;
   logic expire;
   logic next_expire;

   // a zero limit turns the timer off
   always_comb begin
      next_cnt = cnt;
      next_fired = fired;
      next_expire = 1'b0;
      if (i_restart || i_limit == '0) begin
         next_cnt = '0;
         next_fired = 1'b0;
      end else if (i_tick && !fired) begin
         if (cnt + W'(1) >= i_limit) begin
            next_expire = 1'b1;
            next_fired = 1'b1;
         end else begin
            next_cnt = cnt + W'(1);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt <= '0;
         fired <= 1'b0;
         expire <= 1'b0;
      end else begin
         cnt <= next_cnt;
         fired <= next_fired;
         expire <= next_expire;
      end
   end

   assign o_expire = expire;
endmodule : dpsc_timer
`default_nettype wire

// ==== src/dpsc_top.sv ====
// drive power state and interface link power management control
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] power-up-into-standby enable is set by feature command and kept nonvolatile
// [R2] after powering up into standby, stay there until the spin-up subcommand
// [R3] identify in power-up standby flags word 0 bit 2 as incomplete
// [R4] power management level accepted from 01h to FEh only
// [R5] host uses separate subcommands to enable and disable power management
// [R6] standby on standby-timer expiry or level-based timer expiry, independently
// [R7] identify reports support w83 b3, enabled w86 b3, level w91 low byte
// [R8] accept host link power requests and start device requests
// [R9] entering standby starts a device low-power link request
// [R10] partial request only when partial enabled and host reports partial capability
// [R11] slumber request only when slumber enabled and host reports slumber capability
// [R12] with low-power enabled, accept host request with acknowledge
// [R13] supported but disabled low-power: refuse every request with negative acknowledge
// [R14] active link can transmit and respond
// [R15] partial holds, ignoring idle patterns, until wake or reset signalling
// [R16] slumber holds, ignoring idle patterns, until wake or reset signalling
// [R17] 05h enables with level from count, 85h disables; both survive link reset
// [R18] link reset signalling acts as hardware reset, requested or not
// [R19] wake returns link to active; link reset restarts the link
module dpsc_top #(
   parameter int TICK_CYC = dpsc_pkg::TICK_CYC,
   parameter int TMR_W = 16
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire dpsc_pkg::dpsc_feat_t i_feat,
   input wire logic i_activity,
   input wire logic i_standby_cmd,
   input wire logic [TMR_W-1:0] i_standby_ticks,
   input wire logic i_nv_puis,
   input wire logic i_lpm_supported,
   input wire logic i_partial_en,
   input wire logic i_slumber_en,
   input wire logic i_host_partial_cap,
   input wire logic i_host_slumber_cap,
   input wire logic i_dipm_en,
   input wire dpsc_pkg::dpsc_prim_t i_rx,
   input wire dpsc_pkg::dpsc_oob_t i_oob,
   output dpsc_pkg::dpsc_prim_t o_tx,
   output dpsc_pkg::dpsc_pwr_t o_pwr_state,
   output dpsc_pkg::dpsc_link_t o_link_state,
   output logic o_link_ready,
   output logic o_link_reset,
   output logic o_feat_abort,
   output logic o_nv_wr,
   output logic o_nv_puis,
   output dpsc_pkg::dpsc_id_t o_id
);
   localparam int TMO_W = $clog2(dpsc_pkg::REQ_TMO_CYC + 1);

   // settings and power state
   dpsc_pkg::dpsc_pwr_t pwr, next_pwr;
   logic booted, next_booted;
   logic puis_en, next_puis_en;
   logic apm_en, next_apm_en;
   logic [7:0] apm_level, next_apm_level;
   logic nv_wr, next_nv_wr;
   logic abort, next_abort;
   logic lp_start, next_lp_start;
   dpsc_pkg::dpsc_id_t id, next_id;
   logic tick, stby_exp, apm_exp, tmr_restart;
   logic [TMR_W-1:0] apm_limit;

   dpsc_tick #(.CYC(TICK_CYC)) u_tick (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .o_tick(tick)
   );

   // timers only run while spun up and idle
   assign tmr_restart = i_activity || pwr != dpsc_pkg::P_ACTIVE;
   // low levels let the level-based algorithm spin down after level * 256 ticks
   assign apm_limit = (apm_en && apm_level < dpsc_pkg::APM_STBY_BAND) ?
                      TMR_W'({apm_level, 8'h00}) : '0;

   dpsc_timer #(.W(TMR_W)) u_stby_tmr (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_tick(tick),
      .i_restart(tmr_restart),
      .i_limit(i_standby_ticks),
      .o_expire(stby_exp)
   );

   dpsc_timer #(.W(TMR_W)) u_apm_tmr (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_tick(tick),
      .i_restart(tmr_restart),
      .i_limit(apm_limit),
      .o_expire(apm_exp)
   );

   logic feat_spinup;
   assign feat_spinup = i_feat.valid && i_feat.sub == dpsc_pkg::SF_SPINUP;

   always_comb begin
      next_pwr = pwr;
      next_booted = 1'b1;
      next_puis_en = puis_en;
      next_apm_en = apm_en;
      next_apm_level = apm_level;
      next_nv_wr = 1'b0;
      next_abort = 1'b0;
      if (!booted) begin
         // nonvolatile enable is caught at the first edge after reset release
         next_puis_en = i_nv_puis; // R1
         next_pwr = i_nv_puis ? dpsc_pkg::P_PUIS : dpsc_pkg::P_ACTIVE; // R2
      end else begin
         if (i_feat.valid) begin
            case (i_feat.sub)
               dpsc_pkg::SF_APM_ON: begin
                  if (i_feat.count >= dpsc_pkg::APM_MIN && i_feat.count <= dpsc_pkg::APM_MAX) begin // R4
                     next_apm_en = 1'b1; // R17
                     next_apm_level = i_feat.count;
                  end else begin
                     next_abort = 1'b1;
                  end
               end
               dpsc_pkg::SF_APM_OFF: next_apm_en = 1'b0; // R17
               dpsc_pkg::SF_PUIS_ON: begin
                  next_puis_en = 1'b1; // R1
                  next_nv_wr = 1'b1;
               end
               dpsc_pkg::SF_PUIS_OFF: begin
                  next_puis_en = 1'b0; // R1
                  next_nv_wr = 1'b1;
               end
               dpsc_pkg::SF_SPINUP: ;
               default: next_abort = 1'b1;
            endcase
         end
         case (pwr)
            dpsc_pkg::P_PUIS: begin
               if (feat_spinup) next_pwr = dpsc_pkg::P_ACTIVE; // R2
            end
            dpsc_pkg::P_ACTIVE: begin
               if (i_standby_cmd || stby_exp || apm_exp) next_pwr = dpsc_pkg::P_STANDBY; // R6
            end
            dpsc_pkg::P_STANDBY: begin
               if (i_activity || feat_spinup) next_pwr = dpsc_pkg::P_ACTIVE;
            end
            default: next_pwr = dpsc_pkg::P_ACTIVE;
         endcase
      end
      next_lp_start = booted && next_pwr != dpsc_pkg::P_ACTIVE && pwr == dpsc_pkg::P_ACTIVE;
      next_id = '0;
      next_id.w0[dpsc_pkg::ID_W0_INCOMPLETE_BIT] = (pwr == dpsc_pkg::P_PUIS); // R3
      next_id.w83[dpsc_pkg::ID_W83_APM_BIT] = 1'b1; // R7
      next_id.w86[dpsc_pkg::ID_W86_APM_BIT] = apm_en; // R7
      next_id.w91[7:0] = apm_en ? apm_level : 8'h00; // R7
   end

   // power-on reset only: a link reset leaves these settings alone
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pwr <= dpsc_pkg::P_ACTIVE;
         booted <= 1'b0;
         puis_en <= 1'b0;
         apm_en <= 1'b0;
         apm_level <= dpsc_pkg::APM_RST_LVL;
         nv_wr <= 1'b0;
         abort <= 1'b0;
         lp_start <= 1'b0;
         id <= '0;
      end else begin
         pwr <= next_pwr;
         booted <= next_booted;
         puis_en <= next_puis_en;
         apm_en <= next_apm_en;
         apm_level <= next_apm_level;
         nv_wr <= next_nv_wr;
         abort <= next_abort;
         lp_start <= next_lp_start;
         id <= next_id;
      end
   end

   // interface link power management
   dpsc_pkg::dpsc_link_t link, next_link;
   logic [TMO_W-1:0] tmo, next_tmo;
   logic ack, next_ack, nak, next_nak, lrst, next_lrst;
   logic can_p, can_s, host_req;

   assign can_p = i_partial_en && i_host_partial_cap; // R10
   assign can_s = i_slumber_en && i_host_slumber_cap; // R11
   assign host_req = i_rx.pmreq_p || i_rx.pmreq_s;

   always_comb begin
      next_link = link;
      next_tmo = '0;
      next_ack = 1'b0;
      next_nak = 1'b0;
      next_lrst = 1'b0;
      if (i_oob.comreset) begin
         next_link = dpsc_pkg::L_ACTIVE; // R18
         next_lrst = 1'b1; // R19
      end else begin
         case (link)
            dpsc_pkg::L_ACTIVE: begin
               if (i_rx.pmreq_p && i_partial_en) begin
                  next_ack = 1'b1; // R12
                  next_link = dpsc_pkg::L_PARTIAL;
               end else if (i_rx.pmreq_s && i_slumber_en) begin
                  next_ack = 1'b1; // R12
                  next_link = dpsc_pkg::L_SLUMBER;
               end else if (host_req) begin
                  next_nak = 1'b1; // R13
               end else if (lp_start && i_dipm_en && i_lpm_supported) begin // R8
                  if (can_s) next_link = dpsc_pkg::L_REQ_S; // R9
                  else if (can_p) next_link = dpsc_pkg::L_REQ_P; // R9
               end
            end
            dpsc_pkg::L_REQ_P, dpsc_pkg::L_REQ_S: begin
               next_tmo = tmo + TMO_W'(1);
               if (i_rx.pmack) begin
                  next_link = (link == dpsc_pkg::L_REQ_P) ? dpsc_pkg::L_PARTIAL : dpsc_pkg::L_SLUMBER;
               end else if (i_rx.pmnak || tmo == TMO_W'(dpsc_pkg::REQ_TMO_CYC)) begin
                  next_link = dpsc_pkg::L_ACTIVE;
               end else if ((link == dpsc_pkg::L_REQ_P && !can_p) || (link == dpsc_pkg::L_REQ_S && !can_s)) begin
                  next_link = dpsc_pkg::L_ACTIVE; // R10
               end
            end
            dpsc_pkg::L_PARTIAL, dpsc_pkg::L_SLUMBER: begin
               // only wake or link reset signalling leaves; idle patterns on the line do nothing
               if (i_oob.comwake) next_link = dpsc_pkg::L_ACTIVE; // R15 R16
            end
            default: next_link = dpsc_pkg::L_ACTIVE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         link <= dpsc_pkg::L_ACTIVE;
         tmo <= '0;
         ack <= 1'b0;
         nak <= 1'b0;
         lrst <= 1'b0;
      end else begin
         link <= next_link;
         tmo <= next_tmo;
         ack <= next_ack;
         nak <= next_nak;
         lrst <= next_lrst;
      end
   end

   always_comb begin
      o_tx.pmreq_p = link == dpsc_pkg::L_REQ_P && can_p; // R10
      o_tx.pmreq_s = link == dpsc_pkg::L_REQ_S && can_s; // R11
      o_tx.pmack = ack;
      o_tx.pmnak = nak;
   end

   assign o_link_ready = link == dpsc_pkg::L_ACTIVE; // R14
   assign o_link_state = link;
   assign o_link_reset = lrst;
   assign o_pwr_state = pwr;
   assign o_feat_abort = abort;
   assign o_nv_wr = nv_wr;
   assign o_nv_puis = puis_en;
   assign o_id = id;

   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_host_partial;
      link == dpsc_pkg::L_ACTIVE && !i_oob.comreset && i_rx.pmreq_p;
   endsequence
   sequence s_enter_standby;
      booted && pwr == dpsc_pkg::P_ACTIVE && next_pwr == dpsc_pkg::P_STANDBY;
   endsequence
   property p_puis_hold;
      pwr == dpsc_pkg::P_PUIS && !feat_spinup |=> pwr == dpsc_pkg::P_PUIS;
   endproperty
   a_puis_hold: assert property (p_puis_hold) else $error("left power-up standby without spin-up"); // R2
   property p_spinup;
      booted && pwr == dpsc_pkg::P_PUIS && feat_spinup |=> pwr == dpsc_pkg::P_ACTIVE;
   endproperty
   a_spinup: assert property (p_spinup) else $error("spin-up did not reach active"); // R2
   property p_incomplete;
      booted |=> o_id.w0[dpsc_pkg::ID_W0_INCOMPLETE_BIT] == ($past(pwr) == dpsc_pkg::P_PUIS);
   endproperty
   a_incomplete: assert property (p_incomplete) else $error("incomplete flag wrong"); // R3
   property p_level_range;
      booted && i_feat.valid && i_feat.sub == dpsc_pkg::SF_APM_ON && (i_feat.count == 8'h00 || i_feat.count == 8'hFF)
      |=> o_feat_abort && $stable(apm_level) ##1 o_id.w91[7:0] != 8'hFF;
   endproperty
   a_level_range: assert property (p_level_range) else $error("out of range level accepted"); // R4
   property p_standby;
      booted && pwr == dpsc_pkg::P_ACTIVE && (stby_exp || apm_exp) |=> pwr == dpsc_pkg::P_STANDBY;
   endproperty
   a_standby: assert property (p_standby) else $error("timer expiry did not enter standby"); // R6
   property p_id_apm;
      booted && i_feat.valid && i_feat.sub == dpsc_pkg::SF_APM_ON && i_feat.count == 8'h40
      |=> ##1 o_id.w86[dpsc_pkg::ID_W86_APM_BIT] && o_id.w91[7:0] == 8'h40;
   endproperty
   a_id_apm: assert property (p_id_apm) else $error("identify power management words wrong"); // R7
   property p_dev_req;
      s_enter_standby ##1 (link == dpsc_pkg::L_ACTIVE && !i_oob.comreset && !host_req && i_dipm_en &&
                           i_lpm_supported && can_s)
      |=> link == dpsc_pkg::L_REQ_S;
   endproperty
   a_dev_req: assert property (p_dev_req) else $error("no device request on entering standby"); // R9
   property p_req_gate;
      o_tx.pmreq_p |-> i_partial_en && i_host_partial_cap && link == dpsc_pkg::L_REQ_P;
   endproperty
   a_req_gate: assert property (p_req_gate) else $error("partial request sent while not allowed"); // R10
   property p_ack;
      s_host_partial and (i_partial_en [*1]) |=> o_tx.pmack && !o_tx.pmnak && link == dpsc_pkg::L_PARTIAL;
   endproperty
   a_ack: assert property (p_ack) else $error("enabled partial request not accepted"); // R12
   property p_nak;
      s_host_partial and (!i_partial_en && i_lpm_supported && !(i_rx.pmreq_s && i_slumber_en))
      |=> o_tx.pmnak && link == dpsc_pkg::L_ACTIVE;
   endproperty
   a_nak: assert property (p_nak) else $error("disabled partial request not refused"); // R13
   property p_low_hold;
      (link == dpsc_pkg::L_PARTIAL || link == dpsc_pkg::L_SLUMBER) && !i_oob.comwake && !i_oob.comreset
      |=> $stable(link);
   endproperty
   a_low_hold: assert property (p_low_hold) else $error("low-power link state left without signalling"); // R15 R16
   property p_wake;
      link == dpsc_pkg::L_SLUMBER && i_oob.comwake && !i_oob.comreset
      |=> link == dpsc_pkg::L_ACTIVE && !o_link_reset;
   endproperty
   a_wake: assert property (p_wake) else $error("wake did not return link to active"); // R19
   property p_comreset;
      i_oob.comreset |=> o_link_reset && link == dpsc_pkg::L_ACTIVE && $stable(apm_en);
   endproperty
   a_comreset: assert property (p_comreset) else $error("link reset mishandled"); // R18
endmodule : dpsc_top
`default_nettype wire

// ==== sim/dpsc_host.sv ====
// host link partner model: requests, replies and out-of-band events
`timescale 1ns/1ps
`default_nettype none
module dpsc_host (
   input wire logic i_clk,
   input wire dpsc_pkg::dpsc_prim_t i_tx,
   output dpsc_pkg::dpsc_prim_t o_rx,
   output dpsc_pkg::dpsc_oob_t o_oob
);
   int reply = 0;
   int delay = 0;
   initial begin
      o_rx = '0;
      o_oob = '0;
   end
   // answers each device request once, 1 accepts, 2 refuses
   always begin
      @(posedge i_clk);
      if ((i_tx.pmreq_p || i_tx.pmreq_s) && reply != 0) begin
         repeat (delay) @(posedge i_clk);
         #1 o_rx = {2'b00, reply == 1, reply == 2};
         @(posedge i_clk);
         #1 o_rx = '0;
         while (i_tx.pmreq_p || i_tx.pmreq_s) @(posedge i_clk);
      end
   end
   task automatic pulse(input logic [3:0] p, input logic [1:0] o);
      o_rx = p;
      o_oob = o;
      @(posedge i_clk);
      #1 o_rx = '0;
      o_oob = '0;
   endtask : pulse
endmodule : dpsc_host
`default_nettype wire

// ==== sim/tb_drive_power_state_control.sv ====
// self-checking bench of the power-state control block
`timescale 1ns/1ps
`default_nettype none
module tb_drive_power_state_control;
   logic i_clk = 0;
   logic i_nrst = 0;
   dpsc_pkg::dpsc_feat_t feat = '0;
   logic act = 0, scmd = 0, nvp = 1, pen = 0, sen = 0, pcap = 1, scap = 1, dipm = 1;
   logic [15:0] sticks = 16'h0000;
   dpsc_pkg::dpsc_prim_t rx, tx;
   dpsc_pkg::dpsc_oob_t oob;
   dpsc_pkg::dpsc_pwr_t pwr, m_pwr;
   dpsc_pkg::dpsc_link_t lnk, m_link;
   logic rdy, lrst, abrt, nvwr, nvq;
   dpsc_pkg::dpsc_id_t id;
   int mismatches = 0, samples_checked = 0, m_en = 0, m_lvl = 0, n;
   logic [31:0] seed = 32'h0000_DF19;
   always #5 i_clk = ~i_clk;
   dpsc_top #(.TICK_CYC(4), .TMR_W(16)) i_dpsc_top (.i_clk(i_clk), .i_nrst(i_nrst), .i_feat(feat),
      .i_activity(act), .i_standby_cmd(scmd), .i_standby_ticks(sticks), .i_nv_puis(nvp),
      .i_lpm_supported(1'b1), .i_partial_en(pen), .i_slumber_en(sen), .i_host_partial_cap(pcap),
      .i_host_slumber_cap(scap), .i_dipm_en(dipm), .i_rx(rx), .i_oob(oob), .o_tx(tx),
      .o_pwr_state(pwr), .o_link_state(lnk), .o_link_ready(rdy), .o_link_reset(lrst),
      .o_feat_abort(abrt), .o_nv_wr(nvwr), .o_nv_puis(nvq), .o_id(id));
   dpsc_host i_dpsc_host (.i_clk(i_clk), .i_tx(tx), .o_rx(rx), .o_oob(oob));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic step(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask : step
   // state and identify fields against the model
   task automatic chk_st();
      check({pwr, lnk, rdy, id.w0[2], id.w83[3], id.w86[3], id.w91[7:0]}, {m_pwr, m_link,
         m_link == dpsc_pkg::L_ACTIVE, m_pwr == dpsc_pkg::P_PUIS, 1'b1, m_en[0], m_en ? m_lvl[7:0] : 8'h00});
   endtask : chk_st
   task automatic fcmd(input logic [7:0] s, input logic [7:0] c);
      logic ab;
      ab = 0;
      case (s)
         8'h05: if (c == 8'h00 || c == 8'hFF) ab = 1; else begin m_en = 1; m_lvl = c; end
         8'h85: m_en = 0;
         8'h0A, 8'h8A: ;
         8'h07: m_pwr = dpsc_pkg::P_ACTIVE;
         default: ab = 1;
      endcase
      feat = {1'b1, s, c};
      step(1);
      feat.valid = 1'b0;
      check({abrt, nvwr}, {ab, s == 8'h0A || s == 8'h8A});
      step(1);
      chk_st();
   endtask : fcmd
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude
   initial begin
      #60_000;
      mismatches++;
      conclude();
   end
   initial begin
      logic [7:0] lv [5];
      lv = '{8'h00, 8'h01, 8'hFF, 8'h40, 8'hFE};
      m_pwr = dpsc_pkg::P_ACTIVE;
      m_link = dpsc_pkg::L_ACTIVE;
      repeat (10) @(posedge i_clk);
      #1 i_nrst = 1;
      m_pwr = dpsc_pkg::P_PUIS;
      step(3);
      chk_st();
      check(nvq, 1'b1);
      act = 1;
      step(1);
      act = 0;
      step(2);
      chk_st();
      fcmd(8'h07, 8'h00);
      fcmd(8'h8A, 8'h00);
      check(nvq, 1'b0);
      fcmd(8'h0A, 8'h00);
      check(nvq, 1'b1);
      fcmd(8'h33, 8'h00);
      fcmd(8'h05, 8'(rnd() % 254 + 1));
      fcmd(8'h85, 8'h00);
      for (int k = 0; k < 5; k++) fcmd(8'h05, lv[k]);
      i_dpsc_host.pulse(4'b1000, 2'b00);
      check({tx.pmack, tx.pmnak}, 2'b01);
      step(1);
      chk_st();
      sen = 1;
      i_dpsc_host.pulse(4'b0100, 2'b00);
      m_link = dpsc_pkg::L_SLUMBER;
      check({tx.pmack, tx.pmnak, lnk}, {2'b10, m_link});
      step(1);
      i_dpsc_host.pulse(4'b1000, 2'b00);
      step(1);
      chk_st();
      i_dpsc_host.pulse(4'b0000, 2'b10);
      m_link = dpsc_pkg::L_ACTIVE;
      check({lnk, lrst}, {m_link, 1'b0});
      step(1);
      pen = 1;
      i_dpsc_host.pulse(4'b1100, 2'b00);
      m_link = dpsc_pkg::L_PARTIAL;
      check({tx.pmack, lnk}, {1'b1, m_link});
      step(1);
      i_dpsc_host.pulse(4'b0100, 2'b00);
      step(1);
      chk_st();
      i_dpsc_host.pulse(4'b0000, 2'b01);
      m_link = dpsc_pkg::L_ACTIVE;
      check({lnk, lrst}, {m_link, 1'b1});
      step(1);
      chk_st();
      i_dpsc_host.reply = 1;
      i_dpsc_host.delay = 3;
      scmd = 1;
      step(1);
      scmd = 0;
      m_pwr = dpsc_pkg::P_STANDBY;
      for (n = 0; n < 5 && tx.pmreq_s !== 1'b1; n++) step(1);
      check({tx.pmreq_p, tx.pmreq_s}, 2'b01);
      for (n = 0; n < 10 && lnk === dpsc_pkg::L_REQ_S; n++) step(1);
      m_link = dpsc_pkg::L_SLUMBER;
      step(1);
      chk_st();
      i_dpsc_host.pulse(4'b0000, 2'b10);
      m_link = dpsc_pkg::L_ACTIVE;
      act = 1;
      step(1);
      act = 0;
      m_pwr = dpsc_pkg::P_ACTIVE;
      step(1);
      chk_st();
      scap = 0;
      i_dpsc_host.reply = 2;
      i_dpsc_host.delay = 0;
      scmd = 1;
      step(1);
      scmd = 0;
      for (n = 0; n < 5 && tx.pmreq_p !== 1'b1; n++) step(1);
      check({tx.pmreq_p, tx.pmreq_s}, 2'b10);
      for (n = 0; n < 10 && lnk === dpsc_pkg::L_REQ_P; n++) step(1);
      check(lnk, dpsc_pkg::L_ACTIVE);
      act = 1;
      step(1);
      act = 0;
      dipm = 0;
      sticks = 16'h0003;
      for (n = 0; n < 40 && pwr === dpsc_pkg::P_ACTIVE; n++) step(1);
      check(pwr, dpsc_pkg::P_STANDBY);
      step(2);
      check(lnk, dpsc_pkg::L_ACTIVE);
      dipm = 1;
      sticks = 16'h0000;
      step(20);
      act = 1;
      step(1);
      act = 0;
      fcmd(8'h05, 8'h01);
      for (n = 0; n < 1100 && pwr === dpsc_pkg::P_ACTIVE; n++) step(1);
      check({n >= 900, pwr}, {1'b1, dpsc_pkg::P_STANDBY});
      i_nrst = 0;
      step(2);
      nvp = 0;
      i_nrst = 1;
      m_pwr = dpsc_pkg::P_ACTIVE;
      m_link = dpsc_pkg::L_ACTIVE;
      m_en = 0;
      step(3);
      chk_st();
      check(nvq, 1'b0);
      conclude();
   end
endmodule : tb_drive_power_state_control
`default_nettype wire
